// ==== design/nsc_regs.sv ====
`timescale 1ns/1ps
`include "nsc_consts.svh"

module nsc_regs
	import nsc_pkg::*;
#(
	parameter logic [15:0] PART_NUMBER = 16'h0A5A, // Arbitrary value.
	parameter logic [3:0]  VERSION     = 4'h1      // Arbitrary value.
)
(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire nsc_csr_req_t csr_req,
	output nsc_csr_rsp_t      csr_rsp,
	input  wire logic [7:0]   mc_exist_pins,
	input  wire logic         bridge_inst_pin,
	input  wire logic         bridge_wide_pin,
	input  wire logic [2:0]   agent_id_pins,
	input  wire logic [3:0]   proc_inst_pins,
	input  wire logic [2:0]   chk_agent,
	output logic              agent_ok,
	input  wire logic [2:0]   chk_mc,
	output logic              mc_ok,
	output logic              bridge_ok,
	output logic [3:0]        proc_ok,
	input  wire logic [6:0]   vindex_in,
	output logic [6:0]        vindex_out,
	input  wire logic         req_odd,
	output logic              board_odd,
	output logic [7:0]        bcast_agents,
	output logic [3:0]        bus_span,
	output logic [3:0]        bank_span,
	output logic [1:0]        brd_ilv,
	output logic [1:0]        fnz_size,
	output logic [3:0]        node_id,
	output logic [2:0]        inter_mc
);

	// Online masks, cleared by reset.
	logic [7:0]  ag_onl_q;
	logic [7:0]  mc_onl_q;
	// Controller existence, captured from the straps.
	logic [7:0]  mc_exist_q;
	// Fields that keep their value across reset.
	logic [3:0]  bus_span_q;
	logic [3:0]  bank_span_q;
	logic [6:0]  vindex_mask_q;
	logic        brd_route_q;
	logic [2:0]  ha_q;
	logic [1:0]  brd_ilv_q;
	logic [1:0]  fnz_q;
	logic [3:0]  node_id_q;
	logic [7:0]  subcplx_q;
	logic [2:0]  inter_mc_q;
	// Bridge online, cleared by reset.
	logic        br_onl_q;
	// Per-slot implementation bits and per-bus online bits.
	logic [2:0]  impl_q [4];
	logic [1:0]  bus_onl_q;
	// Low while reset is held and up to the first edge after release.
	logic        init_q;
	// Answer registers.
	logic        ack_q;
	logic [63:0] rdata_q;
	logic [63:0] rdata_d;
	// Decoded write strobes.
	logic        wr_sys;
	logic        wr_ag;
	logic [3:0]  wr_slot;
	logic        slot_hit;
	logic [1:0]  slot_idx;
	logic [2:0]  slot_off;

	// Decode a write; a write to an unknown select hits nothing.
	always_comb
	begin
		wr_sys   = csr_req.valid && csr_req.write
			&& (csr_req.sel == `NSC_SEL_SYS);
		wr_ag    = csr_req.valid && csr_req.write
			&& (csr_req.sel == `NSC_SEL_AGENT);
		slot_off = csr_req.sel - `NSC_SEL_SLOT0;
		slot_hit = (csr_req.sel >= `NSC_SEL_SLOT0)
			&& (slot_off < 3'h4);
		slot_idx = slot_off[1:0];
		wr_slot  = 4'h0;
		if (csr_req.valid && csr_req.write && slot_hit)
		begin
			wr_slot[slot_idx] = 1'b1;
		end
	end

	// The straps are caught on every edge while init_q is low, up to the
	// first edge after release, so the asynchronous reset loads nothing but constants.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			init_q <= 1'b0;
		end
		else
		begin
			init_q <= 1'b1;
		end
	end

	// Existence is loaded from the straps; writes never touch it.
	always_ff @(posedge core_clk)
	begin
		if (!init_q)
		begin
			mc_exist_q <= mc_exist_pins; // [RQ4]
		end
	end

	// Online masks: cleared by reset, then under software control.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ag_onl_q <= `NSC_RST_ONL8; // [RQ2]
			mc_onl_q <= `NSC_RST_ONL8; // [RQ3]
			br_onl_q <= 1'b0; // [RQ15]
		end
		else
		begin
			if (wr_sys)
			begin
				ag_onl_q <= csr_req.wdata[`NSC_SYS_AG_ONL]; // [RQ2]
				mc_onl_q <= csr_req.wdata[`NSC_SYS_MC_ONL]; // [RQ3]
			end
			if (wr_ag)
			begin
				br_onl_q <= csr_req.wdata[`NSC_AG_BR_ONL]; // [RQ15]
			end
		end
	end

	// Configuration fields with no reset: a warm reset must not lose the
	// interleave and identity setup. Until first written they are
	// undefined, which firmware must cover.
	always_ff @(posedge core_clk)
	begin
		if (wr_sys)
		begin
			bus_span_q  <= csr_req.wdata[`NSC_SYS_BUS_SPAN]; // [RQ1] [RQ5]
			bank_span_q <= csr_req.wdata[`NSC_SYS_BANK_SPAN]; // [RQ6]
			vindex_mask_q <= csr_req.wdata[`NSC_SYS_VIDX_MASK]; // [RQ7]
			brd_route_q <= csr_req.wdata[`NSC_SYS_BRD_ROUTE]; // [RQ8]
			ha_q        <= csr_req.wdata[`NSC_SYS_HA]; // [RQ9]
			brd_ilv_q   <= csr_req.wdata[`NSC_SYS_BRD_ILV]; // [RQ10]
			fnz_q       <= csr_req.wdata[`NSC_SYS_FNZ_SIZE]; // [RQ11]
			node_id_q   <= csr_req.wdata[`NSC_SYS_NODE_ID]; // [RQ12]
		end
		if (wr_ag)
		begin
			subcplx_q  <= csr_req.wdata[`NSC_AG_SUBCPLX]; // [RQ14]
			inter_mc_q <= csr_req.wdata[`NSC_AG_INTER_MC]; // [RQ18]
		end
	end

	// Per-slot implementation bits, held as written.
	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (wr_slot[i])
			begin
				impl_q[i] <= csr_req.wdata[`NSC_PS_IMPL]; // [RQ20]
			end
		end
	end

	// Bus online is one bit per bus, so a write through either slot of a
	// bus changes what both slots read. After reset it copies the
	// installed straps of that bus.
	always_ff @(posedge core_clk)
	begin
		if (!init_q)
		begin
			bus_onl_q[0] <= |proc_inst_pins[1:0]; // [RQ21]
			bus_onl_q[1] <= |proc_inst_pins[3:2]; // [RQ21]
		end
		else
		begin
			for (int b = 0; b < 2; b++)
			begin
				if (wr_slot[2*b] || wr_slot[2*b+1])
				begin
					bus_onl_q[b] <= csr_req.wdata[`NSC_PS_BUS_ONL]; // [RQ21]
				end
			end
		end
	end

	// Read data; every bit not assembled here reads as zero.
	always_comb
	begin
		rdata_d = 64'h0000_0000_0000_0000; // [RQ24]
		unique case (1'b1)
			csr_req.sel == `NSC_SEL_SYS:
			begin
				rdata_d[`NSC_SYS_AG_ONL]    = ag_onl_q;
				rdata_d[`NSC_SYS_MC_ONL]    = mc_onl_q;
				rdata_d[`NSC_SYS_MC_EXIST]  = mc_exist_q;
				rdata_d[`NSC_SYS_BUS_SPAN]  = bus_span_q; // [RQ1]
				rdata_d[`NSC_SYS_BANK_SPAN] = bank_span_q;
				rdata_d[`NSC_SYS_VIDX_MASK] = vindex_mask_q;
				rdata_d[`NSC_SYS_BRD_ROUTE] = brd_route_q;
				rdata_d[`NSC_SYS_HA]        = ha_q;
				rdata_d[`NSC_SYS_BRD_ILV]   = brd_ilv_q;
				rdata_d[`NSC_SYS_FNZ_SIZE]  = fnz_q;
				rdata_d[`NSC_SYS_NODE_ID]   = node_id_q;
			end
			csr_req.sel == `NSC_SEL_AGENT:
			begin
				rdata_d[`NSC_AG_PART]     = PART_NUMBER; // [RQ13]
				rdata_d[`NSC_AG_VER]      = VERSION; // [RQ13]
				rdata_d[`NSC_AG_SUBCPLX]  = subcplx_q;
				rdata_d[`NSC_AG_BR_ONL]   = br_onl_q;
				rdata_d[`NSC_AG_BR_INST]  = bridge_inst_pin; // [RQ16]
				rdata_d[`NSC_AG_BR_WIDE]  = bridge_wide_pin; // [RQ17]
				rdata_d[`NSC_AG_INTER_MC] = inter_mc_q;
				rdata_d[`NSC_AG_ID]       = agent_id_pins; // [RQ19]
			end
			slot_hit:
			begin
				rdata_d[`NSC_PS_IMPL]    = impl_q[slot_idx];
				rdata_d[`NSC_PS_BUS_ONL] = bus_onl_q[slot_idx[1]];
				rdata_d[`NSC_PS_INST]    = proc_inst_pins[slot_idx]; // [RQ22]
				rdata_d[`NSC_PS_ID]      = slot_idx; // [RQ22]
			end
			default:
			begin
				rdata_d = 64'h0000_0000_0000_0000; // [RQ24]
			end
		endcase
	end

	// Every access is answered on the following edge.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			ack_q <= csr_req.valid;
			if (csr_req.valid && !csr_req.write)
			begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign csr_rsp.ack   = ack_q;
	assign csr_rsp.rdata = rdata_q;

	// Request checks and routing controls. The high-availability bits are
	// stored only; nothing here reads them. This agent keeps only the
	// fields it uses plus those firmware expects to read back.
	always_comb
	begin
		agent_ok     = ag_onl_q[chk_agent]; // [RQ2] [RQ23]
		mc_ok        = mc_onl_q[chk_mc]; // [RQ3]
		bridge_ok    = br_onl_q && bridge_inst_pin; // [RQ15]
		for (int p = 0; p < 4; p++)
		begin
			proc_ok[p] = bus_onl_q[p/2]; // [RQ21]
		end
		vindex_out   = vindex_in & ~vindex_mask_q; // [RQ7]
		board_odd    = req_odd ^ brd_route_q; // [RQ8]
		bcast_agents = subcplx_q; // [RQ14]
		bus_span     = bus_span_q; // [RQ5]
		bank_span    = bank_span_q; // [RQ6]
		brd_ilv      = brd_ilv_q; // [RQ10]
		fnz_size     = fnz_q; // [RQ11]
		node_id      = node_id_q; // [RQ12]
		inter_mc     = inter_mc_q; // [RQ18]
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_ack_next;
		csr_req.valid |=> csr_rsp.ack;
	endproperty
	a_ack_next: assert property (p_ack_next) // [RQ1]
		else $error("Access not answered on next edge.");

	property p_onl_write;
		wr_sys && init_q |=> ag_onl_q == $past(csr_req.wdata[`NSC_B(0):`NSC_B(7)]);
	endproperty
	a_onl_write: assert property (p_onl_write) // [RQ2]
		else $error("Agent online field did not take the write.");

	// Checked from the write path, so a broken field decode is caught;
	// the stored fields are unknown before their first write.
	property p_mc_gate;
		wr_sys && init_q |=> mc_onl_q == $past(csr_req.wdata[`NSC_SYS_MC_ONL]);
	endproperty
	a_mc_gate: assert property (p_mc_gate) // [RQ3]
		else $error("Controller online field did not take the write.");

	property p_exist_kept;
		wr_sys && init_q |=> $stable(mc_exist_q);
	endproperty
	a_exist_kept: assert property (p_exist_kept) // [RQ4]
		else $error("Controller exist field changed on write.");

	property p_vi_mask;
		wr_sys |=> (vindex_out
			& $past(csr_req.wdata[`NSC_SYS_VIDX_MASK])) == 7'h00;
	endproperty
	a_vi_mask: assert property (p_vi_mask) // [RQ7]
		else $error("Masked index bit leaked.");

	property p_route;
		wr_sys |=> (board_odd ^ req_odd)
			== $past(csr_req.wdata[`NSC_SYS_BRD_ROUTE]);
	endproperty
	a_route: assert property (p_route) // [RQ8]
		else $error("Board routing pairing wrong.");

	property p_part_read;
		csr_req.valid && !csr_req.write && csr_req.sel == `NSC_SEL_AGENT
		|=> csr_rsp.rdata[`NSC_B(0):`NSC_B(15)] == PART_NUMBER;
	endproperty
	a_part_read: assert property (p_part_read) // [RQ13]
		else $error("Part number read back wrong.");

	property p_bus_shared;
		wr_slot[0] && init_q |=> proc_ok[1] == $past(csr_req.wdata[5]);
	endproperty
	a_bus_shared: assert property (p_bus_shared) // [RQ21]
		else $error("Bus online not shared by both slots.");

	property p_bridge_gate;
		wr_ag |=> bridge_ok
			== ($past(csr_req.wdata[`NSC_AG_BR_ONL]) && bridge_inst_pin);
	endproperty
	a_bridge_gate: assert property (p_bridge_gate) // [RQ15]
		else $error("Bridge access allowed while offline.");

	property p_unmapped;
		csr_req.valid && !csr_req.write && csr_req.sel > 3'h5
		|=> csr_rsp.rdata == 64'h0000_0000_0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) // [RQ24]
		else $error("Unmapped select returned data.");

	property p_cv_sys_wr;
		wr_sys;
	endproperty
	c_sys_wr: cover property (p_cv_sys_wr);

	property p_cv_slot_rd;
		csr_req.valid && !csr_req.write && slot_hit ##1 csr_rsp.ack;
	endproperty
	c_slot_rd: cover property (p_cv_slot_rd);

	property p_cv_bridge;
		bridge_ok;
	endproperty
	c_bridge: cover property (p_cv_bridge);

endmodule : nsc_regs

// ==== inc/nsc_consts.svh ====
// Function
// RQ1 - System configuration fields writable, readable, reset-preserved.
// RQ2 - Agent online bits gate I/O, local CSR.
// RQ3 - Controller online bits validate memory, CSR requests.
// RQ4 - Controller exist loaded at reset, writes ignored.
// RQ5 - Per-row bus interleave span: four or eight.
// RQ6 - Bank interleave span bits: two or four banks.
// RQ7 - Virtual index mask forces index bits zero.
// RQ8 - Board routing bit swaps even/odd board pairing.
// RQ9 - High-availability bits stored, drive nothing.
// RQ10 - Board interleave pair count; value two reserved.
// RQ11 - Forced node zero region size or disabled.
// RQ12 - Node identification number held in system register.
// RQ13 - Part number and version hard-wired, read-only.
// RQ14 - Subcomplex mask selects broadcast receivers, forward all.
// RQ15 - Bridge online set by software, reset clears.
// RQ16 - Read-only bridge installed bit.
// RQ17 - Read-only bridge width bit, one 32-bit.
// RQ18 - Intermediate controller field names routing hop.
// RQ19 - Agent identification reads input pins, writes ignored.
// RQ20 - Four slot registers; implementation bits left alone.
// RQ21 - Shared bus online gates processor, reset copies installed.
// RQ22 - Installed bit live pin; processor id fixed.
// RQ23 - Only fields used by controller implemented; the code also keeps fields it never uses, such as the high-availability bits.
// RQ24 - Unimplemented bits read zero, writes ignored.
`ifndef NSC_CONSTS_SVH
`define NSC_CONSTS_SVH

// Bit 0 is the most significant bit of the 64-bit word.
`define NSC_B(n) (63 - (n))

// Register selects on the CSR access port.
`define NSC_SEL_SYS       3'h0
`define NSC_SEL_AGENT     3'h1
`define NSC_SEL_SLOT0     3'h2

// System configuration field positions.
`define NSC_SYS_AG_ONL    `NSC_B(0):`NSC_B(7)
`define NSC_SYS_MC_ONL    `NSC_B(8):`NSC_B(15)
`define NSC_SYS_MC_EXIST  `NSC_B(16):`NSC_B(23)
`define NSC_SYS_BUS_SPAN  `NSC_B(24):`NSC_B(27)
`define NSC_SYS_BANK_SPAN `NSC_B(28):`NSC_B(31)
`define NSC_SYS_VIDX_MASK `NSC_B(35):`NSC_B(41)
`define NSC_SYS_BRD_ROUTE `NSC_B(46)
`define NSC_SYS_HA        `NSC_B(48):`NSC_B(50)
`define NSC_SYS_BRD_ILV   `NSC_B(54):`NSC_B(55)
`define NSC_SYS_FNZ_SIZE  `NSC_B(56):`NSC_B(57)
`define NSC_SYS_NODE_ID   `NSC_B(58):`NSC_B(61)

// Agent configuration field positions.
`define NSC_AG_PART       `NSC_B(0):`NSC_B(15)
`define NSC_AG_VER        `NSC_B(16):`NSC_B(19)
`define NSC_AG_SUBCPLX    `NSC_B(32):`NSC_B(39)
`define NSC_AG_BR_ONL     `NSC_B(55)
`define NSC_AG_BR_INST    `NSC_B(56)
`define NSC_AG_BR_WIDE    `NSC_B(57)
`define NSC_AG_INTER_MC   `NSC_B(58):`NSC_B(60)
`define NSC_AG_ID         `NSC_B(61):`NSC_B(63)

// Processor slot configuration field positions.
`define NSC_PS_IMPL       `NSC_B(55):`NSC_B(57)
`define NSC_PS_BUS_ONL    `NSC_B(58)
`define NSC_PS_INST       `NSC_B(59)
`define NSC_PS_ID         `NSC_B(62):`NSC_B(63)

// Reset values of the cleared online fields.
`define NSC_RST_ONL8      8'h00

`endif

// ==== inc/nsc_pkg.sv ====
package nsc_pkg;

	// Register selects carried by a CSR packet access.
	typedef enum logic [2:0] {
		NSC_R_SYS   = 3'b000,
		NSC_R_AGENT = 3'b001,
		NSC_R_SLOT0 = 3'b010,
		NSC_R_SLOT1 = 3'b011,
		NSC_R_SLOT2 = 3'b100,
		NSC_R_SLOT3 = 3'b101
	} nsc_sel_t;

	// One CSR access as decoded from a packet.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [2:0]  sel;
		logic [63:0] wdata;
	} nsc_csr_req_t;

	// Answer to one CSR access.
	typedef struct packed {
		logic        ack;
		logic [63:0] rdata;
	} nsc_csr_rsp_t;

endpackage : nsc_pkg

// ==== testbench/node_system_config_registers_tb.sv ====
`timescale 1ns/1ps
// Compares one value; a mismatch is reported and counted at once.
`define NSC_CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	$display("[ERR] %s exp=%h got=%h", n, e, g); bad_count++; end end

module node_system_config_registers_tb;
	import nsc_pkg::*;

	localparam logic [15:0] PART   = 16'hC3E1; // Arbitrary value.
	localparam logic [3:0]  VER    = 4'h7;     // Arbitrary value.
	// Writable bits; the existence field is kept apart in the model.
	localparam logic [63:0] SYS_RW = 64'hFFFF_00FF_1FC2_E3FC;
	localparam logic [63:0] AG_RW  = 64'h0000_0000_FF00_0138;

	logic         core_clk;
	logic         rst_n;
	nsc_csr_req_t csr_req;
	nsc_csr_rsp_t csr_rsp;
	logic [7:0]   mc_exist_pins;
	logic         bridge_inst_pin;
	logic         bridge_wide_pin;
	logic [2:0]   agent_id_pins;
	logic [3:0]   proc_inst_pins;
	logic [2:0]   chk_agent;
	logic         agent_ok;
	logic [2:0]   chk_mc;
	logic         mc_ok;
	logic         bridge_ok;
	logic [3:0]   proc_ok;
	logic [6:0]   vindex_in;
	logic [6:0]   vindex_out;
	logic         req_odd;
	logic         board_odd;
	logic [7:0]   bcast_agents;
	logic [3:0]   bus_span;
	logic [3:0]   bank_span;
	logic [1:0]   brd_ilv;
	logic [1:0]   fnz_size;
	logic [3:0]   node_id;
	logic [2:0]   inter_mc;
	// Behavioural model of the register contents.
	logic [63:0]  sys_m;
	logic [63:0]  ag_m;
	logic [7:0]   exist_m;
	logic [2:0]   impl_m [4];
	logic [1:0]   bus_m;
	logic [63:0]  rd;
	logic [63:0]  wd;
	int           bad_count;
	int           comparisons;

	nsc_regs #(.PART_NUMBER(PART), .VERSION(VER)) i_nsc_regs (
		.core_clk(core_clk), .rst_n(rst_n), .csr_req(csr_req),
		.csr_rsp(csr_rsp), .mc_exist_pins(mc_exist_pins),
		.bridge_inst_pin(bridge_inst_pin), .bridge_wide_pin(bridge_wide_pin),
		.agent_id_pins(agent_id_pins), .proc_inst_pins(proc_inst_pins),
		.chk_agent(chk_agent), .agent_ok(agent_ok), .chk_mc(chk_mc),
		.mc_ok(mc_ok), .bridge_ok(bridge_ok), .proc_ok(proc_ok),
		.vindex_in(vindex_in), .vindex_out(vindex_out), .req_odd(req_odd),
		.board_odd(board_odd), .bcast_agents(bcast_agents),
		.bus_span(bus_span), .bank_span(bank_span), .brd_ilv(brd_ilv),
		.fnz_size(fnz_size), .node_id(node_id), .inter_mc(inter_mc));

	// Free-running 125 MHz clock.
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Expected read images, built from the model and the live pins.
	function automatic logic [63:0] sys_rd();
		return (sys_m & SYS_RW) | ({56'h0, exist_m} << 40);
	endfunction : sys_rd

	function automatic logic [63:0] ag_rd();
		return (ag_m & AG_RW) | {PART, VER, 44'h0} |
			{56'h0, bridge_inst_pin, bridge_wide_pin, 3'h0, agent_id_pins};
	endfunction : ag_rd

	function automatic logic [63:0] sl_rd(input int k);
		return {55'h0, impl_m[k], bus_m[k/2], proc_inst_pins[k], 2'h0, 2'(k)};
	endfunction : sl_rd

	// One access; the request stays up so a following access is back to back.
	task automatic acc(input logic w, input logic [2:0] s, input logic [63:0] d);
		csr_req.valid = 1'b1;
		csr_req.write = w;
		csr_req.sel   = s;
		csr_req.wdata = d;
		@(posedge core_clk);
		#1;
		`NSC_CHK("ack", 1'b1, csr_rsp.ack)
		rd = csr_rsp.rdata;
	endtask : acc

	// Drops the request and lets one edge pass.
	task automatic idle();
		csr_req.valid = 1'b0;
		@(posedge core_clk);
		#1;
	endtask : idle

	// Sweeps both online selects and checks every decoded output.
	task automatic outs();
		for (int j = 0; j < 8; j++)
		begin
			chk_agent = 3'(j);
			chk_mc    = 3'(j);
			vindex_in = 7'($urandom);
			req_odd   = j[0];
			#2;
			`NSC_CHK("agent_ok", sys_m[56+j], agent_ok)
			`NSC_CHK("mc_ok", sys_m[48+j], mc_ok)
			`NSC_CHK("vindex", vindex_in & ~sys_m[28:22], vindex_out)
			`NSC_CHK("board_odd", req_odd ^ sys_m[17], board_odd)
			@(posedge core_clk);
			#1;
		end
		`NSC_CHK("bus_span", sys_m[39:36], bus_span)
		`NSC_CHK("bank_span", sys_m[35:32], bank_span)
		`NSC_CHK("brd_ilv", sys_m[9:8], brd_ilv)
		`NSC_CHK("fnz_size", sys_m[7:6], fnz_size)
		`NSC_CHK("node_id", sys_m[5:2], node_id)
		`NSC_CHK("bcast", ag_m[31:24], bcast_agents)
		`NSC_CHK("inter_mc", ag_m[5:3], inter_mc)
		`NSC_CHK("bridge_ok", ag_m[8] & bridge_inst_pin, bridge_ok)
		`NSC_CHK("proc_ok", {{2{bus_m[1]}}, {2{bus_m[0]}}}, proc_ok)
	endtask : outs

	// Model of what a reset does: online bits clear, straps are caught.
	task automatic model_reset();
		sys_m[63:48] = 16'h0000;
		ag_m[8]      = 1'b0;
		exist_m      = mc_exist_pins;
		bus_m        = {|proc_inst_pins[3:2], |proc_inst_pins[1:0]};
	endtask : model_reset

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// Cuts a hang short; the tests need well under a thousand cycles.
	initial
	begin
		repeat (4000) @(posedge core_clk);
		bad_count++;
		tally_and_finish();
	end

	initial
	begin
		bad_count   = 0;
		comparisons = 0;
		rst_n       = 1'b0;
		csr_req     = '0;
		void'($urandom(32'h7BAA));
		mc_exist_pins   = 8'($urandom);
		bridge_inst_pin = 1'b1;
		bridge_wide_pin = 1'b0;
		agent_id_pins   = 3'h5;
		proc_inst_pins  = 4'b0100;
		chk_agent = 3'h0;
		chk_mc    = 3'h0;
		vindex_in = 7'h00;
		req_odd   = 1'b0;
		sys_m     = 'x;
		ag_m      = 'x;
		repeat (16) @(posedge core_clk);
		#1;
		model_reset();
		rst_n = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		// The straps were caught at release; later changes must not show.
		mc_exist_pins = ~mc_exist_pins;
		acc(1'b0, NSC_R_SYS, 64'h0);
		wd = sys_rd();
		`NSC_CHK("sys_reset", wd[63:40], rd[63:40])
		idle();
		`NSC_CHK("proc_ok_rst", {2'b11, 2'b00}, proc_ok)
		`NSC_CHK("bridge_ok_rst", 1'b0, bridge_ok)
		$display("test reset done");

		// Agent register: all ones first, then random, pins moving.
		for (int i = 0; i < 2; i++)
		begin
			wd = (i == 0) ? '1 : {$urandom, $urandom};
			bridge_inst_pin = ~bridge_inst_pin;
			bridge_wide_pin = 1'(i);
			agent_id_pins   = 3'($urandom);
			acc(1'b1, NSC_R_AGENT, wd);
			ag_m = wd;
			acc(1'b0, NSC_R_AGENT, 64'h0);
			`NSC_CHK("agent", ag_rd(), rd)
		end
		idle();
		$display("test agent done");

		// System register: every mask size and every coded field value.
		for (int i = 0; i < 8; i++)
		begin
			wd = {$urandom, $urandom};
			wd[28:22] = 7'((1 << i) - 1);
			wd[9:8]   = 2'(i);
			wd[7:6]   = 2'(i >> 1);
			acc(1'b1, NSC_R_SYS, wd);
			sys_m = wd;
			acc(1'b0, NSC_R_SYS, 64'h0);
			`NSC_CHK("sys", sys_rd(), rd)
			idle();
			outs();
		end
		$display("test system done");

		// Slots: each pair shares one online bit, last write wins.
		for (int k = 0; k < 4; k++)
		begin
			wd = {$urandom, $urandom};
			wd[5] = ~k[0];
			acc(1'b1, 3'(2 + k), wd);
			impl_m[k] = wd[8:6];
			bus_m[k/2] = wd[5];
		end
		for (int k = 0; k < 4; k++)
		begin
			acc(1'b0, 3'(2 + k), 64'h0);
			`NSC_CHK("slot", sl_rd(k), rd)
		end
		idle();
		outs();
		$display("test slots done");

		// Unmapped selects: writes vanish, reads give zero.
		for (int k = 6; k < 8; k++)
		begin
			acc(1'b1, 3'(k), '1);
			acc(1'b0, 3'(k), 64'h0);
			`NSC_CHK("unmapped", 64'h0, rd)
		end
		acc(1'b0, NSC_R_SYS, 64'h0);
		`NSC_CHK("sys_kept", sys_rd(), rd)
		idle();
		$display("test unmapped done");

		// Reset in mid-run: stored fields survive, online bits do not.
		rst_n = 1'b0;
		proc_inst_pins = 4'b1001;
		mc_exist_pins  = 8'($urandom);
		repeat (3) @(posedge core_clk);
		#1;
		model_reset();
		rst_n = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		acc(1'b0, NSC_R_SYS, 64'h0);
		`NSC_CHK("sys_rerst", sys_rd(), rd)
		acc(1'b0, NSC_R_AGENT, 64'h0);
		`NSC_CHK("agent_rerst", ag_rd(), rd)
		idle();
		outs();
		$display("test second reset done");
		tally_and_finish();
	end

endmodule : node_system_config_registers_tb
